// ==== common/io_chan_decoder_cfg.svh ====
// constants for the i/o channel instruction decoder
// How it works
// RULE_01: instructions are two to six bytes long
// RULE_02: first two bytes present; operand select bits 7:5
// RULE_03: operand select decodes register, bit or pointer
// RULE_04: bits 4:3 give extra byte count
// RULE_05: short transfers one byte, long two bytes
// RULE_06: displacements are signed two's complement
// RULE_07: byte immediate one byte, word immediate two
// RULE_08: displacement or data, except test-and-set-lock
// RULE_09: extra bytes follow the offset byte
// RULE_10: mode field picks base, offset, index, autoincrement
// RULE_11: bit 0 of first byte selects width
// RULE_12: second byte bits 7:2 hold the opcode
// RULE_13: second byte bits 1:0 select base register
// RULE_14: offset mode adds unsigned third byte
// RULE_15: index mode adds zero-extended index, 64k range
// RULE_16: autoincrement bumps index after every byte
// RULE_17: base codes map a, b, c, parameter
// RULE_18: mode field sits in first byte bits 2:1
`ifndef IO_CHAN_DECODER_CFG_SVH
`define IO_CHAN_DECODER_CFG_SVH

`define IOD_ADDR_W       20
`define IOD_INDEX_W      16
`define IOD_NBYTES       6
`define IOD_OPSEL_HI     7
`define IOD_OPSEL_LO     5
`define IOD_XCNT_HI      4
`define IOD_XCNT_LO      3
`define IOD_AMODE_HI     2
`define IOD_AMODE_LO     1
`define IOD_WIDTH_BIT    0
`define IOD_OPCODE_HI    7
`define IOD_OPCODE_LO    2
`define IOD_BSEL_HI      1
`define IOD_BSEL_LO      0
`define IOD_LEN_MIN      3'h2
`define IOD_LEN_LONG     3'h6
`define IOD_OFFSET_POS   3'h2
`define IOD_OPC_LOAD_PTR_IMM 6'h02
`define IOD_OPC_MEM_MOVE     6'h24
`define IOD_LOAD_PTR_IMM_B0  5'h11
`define IOD_MEM_MOVE_B0      5'h00
`define IOD_RESET_ADDR   20'h0_0000
`define IOD_RESET_INDEX  16'h0000

`endif

// ==== common/io_chan_decoder_pkg.sv ====
// types shared by the i/o channel instruction decoder
package io_chan_decoder_pkg;

    typedef enum logic [2:0] {
        OPR_POINTER_A        = 3'h0,
        OPR_POINTER_B        = 3'h1,
        OPR_POINTER_C        = 3'h2,
        OPR_BYTE_COUNT       = 3'h3,
        OPR_TASK_POINTER     = 3'h4,
        OPR_INDEX            = 3'h5,
        OPR_CHANNEL_CONTROL  = 3'h6,
        OPR_MASK_COMPARE     = 3'h7
    } operand_reg_t;

    typedef enum logic [1:0] {
        AM_BASE        = 2'h0,
        AM_BASE_OFFSET = 2'h1,
        AM_BASE_INDEX  = 2'h2,
        AM_INDEX_AUTO  = 2'h3
    } addr_mode_t;

    typedef enum logic [1:0] {
        BASE_POINTER_A   = 2'h0,
        BASE_POINTER_B   = 2'h1,
        BASE_POINTER_C   = 2'h2,
        BASE_PARAM_PTR   = 2'h3
    } base_sel_t;

    typedef struct packed {
        logic [5:0][7:0] b;
    } instr_bytes_t;

    typedef struct packed {
        logic [19:0] pointer_a;
        logic [19:0] pointer_b;
        logic [19:0] pointer_c;
        logic [19:0] parameter_pointer;
    } pointer_set_t;

    typedef struct packed {
        operand_reg_t reg_sel;
        logic [2:0]   bit_num;
        logic         ptr_valid;
        logic [1:0]   extra_byte_count_field;
        addr_mode_t   address_mode_field;
        logic         word;
        logic [5:0]   opcode;
        base_sel_t    base_select_field;
        logic         is_test_and_set_lock;
        logic         is_load_pointer_immediate;
        logic         is_mem_move;
    } fields_t;

    typedef struct packed {
        logic [2:0]  length;
        logic        offset_present;
        logic [7:0]  offset;
        logic [2:0]  extra_pos;
        logic [1:0]  extra_count;
        logic [15:0] disp;
        logic [15:0] imm;
    } layout_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACTIVE = 2'b10
    } dec_state_t;

endpackage : io_chan_decoder_pkg

// ==== hw/io_chan_decoder.sv ====
// i/o channel instruction decoder with effective address former
`timescale 1ns/10ps
`include "io_chan_decoder_cfg.svh"

module io_chan_decoder (
    input  wire logic                             i_mclk,
    input  wire logic                             i_sys_rst,
    input  wire logic                             i_ce,
    input  wire logic                             i_decode_valid,
    input  wire io_chan_decoder_pkg::instr_bytes_t i_instr,
    input  wire io_chan_decoder_pkg::pointer_set_t i_pointers,
    input  wire logic [15:0]                      i_index_register,
    input  wire logic                             i_byte_done,
    input  wire logic                             i_release,
    output logic                                  o_decode_valid,
    output io_chan_decoder_pkg::fields_t          o_fields,
    output io_chan_decoder_pkg::layout_t          o_layout,
    output logic [19:0]                           o_eff_addr,
    output logic [15:0]                           o_index_value,
    output logic                                  o_index_wr,
    output logic                                  o_busy
);
    import io_chan_decoder_pkg::*;

    // first two bytes, always present
    logic [7:0]   b0;
    logic [7:0]   b1;
    fields_t      fields_d;
    layout_t      layout_d;
    logic [2:0]   pos;
    logic [1:0]   xcnt;
    logic [7:0]   x_lo;
    logic [7:0]   x_hi;
    logic [19:0]  base_d;
    logic [19:0]  ea_d;
    logic         is_tsl;
    logic         is_load_pointer_immediate_instruction;
    logic         is_mm;

    dec_state_t   state_q;
    dec_state_t   state_d;
    fields_t      fields_q;
    layout_t      layout_q;
    logic [19:0]  base_q;
    logic [15:0]  index_q;
    logic [19:0]  ea_q;
    logic         valid_q;
    logic         index_wr_q;
    logic         busy_q;

    assign b0 = i_instr.b[0]; // RULE_02
    assign b1 = i_instr.b[1]; // RULE_02

    // field split of the first two bytes
    always_comb begin
        fields_d = '0;
        fields_d.reg_sel = operand_reg_t'(b0[`IOD_OPSEL_HI:`IOD_OPSEL_LO]); // RULE_02 RULE_03
        fields_d.bit_num = b0[`IOD_OPSEL_HI:`IOD_OPSEL_LO]; // RULE_03
        // only a, b, c and task pointer can name a pointer
        case (b0[`IOD_OPSEL_HI:`IOD_OPSEL_LO])
            3'h0, 3'h1, 3'h2, 3'h4: begin
                fields_d.ptr_valid = 1'b1; // RULE_03
            end
            default: begin
                fields_d.ptr_valid = 1'b0; // RULE_03
            end
        endcase
        fields_d.extra_byte_count_field = b0[`IOD_XCNT_HI:`IOD_XCNT_LO]; // RULE_04
        fields_d.address_mode_field = addr_mode_t'(b0[`IOD_AMODE_HI:`IOD_AMODE_LO]); // RULE_18 RULE_10
        fields_d.word = b0[`IOD_WIDTH_BIT]; // RULE_11
        fields_d.opcode = b1[`IOD_OPCODE_HI:`IOD_OPCODE_LO]; // RULE_12
        fields_d.base_select_field = base_sel_t'(b1[`IOD_BSEL_HI:`IOD_BSEL_LO]); // RULE_13 RULE_17
        fields_d.is_test_and_set_lock = is_tsl;
        fields_d.is_load_pointer_immediate = is_load_pointer_immediate_instruction;
        fields_d.is_mem_move = is_mm;
    end

    // special forms; tsl recognised from the first byte alone, the two long forms from both bytes
    assign is_tsl = (b0[`IOD_XCNT_HI:`IOD_XCNT_LO] == 2'h3); // RULE_04
    assign is_load_pointer_immediate_instruction = (b1[`IOD_OPCODE_HI:`IOD_OPCODE_LO] == `IOD_OPC_LOAD_PTR_IMM)
                  && (b0[4:0] == `IOD_LOAD_PTR_IMM_B0); // RULE_01
    assign is_mm = (b1[`IOD_OPCODE_HI:`IOD_OPCODE_LO] == `IOD_OPC_MEM_MOVE)
                && (b0[7:3] == `IOD_MEM_MOVE_B0); // RULE_01

    // tsl carries one displacement and one data byte
    always_comb begin
        case (b0[`IOD_XCNT_HI:`IOD_XCNT_LO])
            2'h0: begin
                xcnt = 2'h0; // RULE_04
            end
            2'h1: begin
                xcnt = 2'h1; // RULE_04
            end
            default: begin
                xcnt = 2'h2; // RULE_04 RULE_08
            end
        endcase
    end

    // trailing bytes sit behind the offset byte when there is one
    assign pos = (b0[`IOD_AMODE_HI:`IOD_AMODE_LO] == 2'h1)
               ? (`IOD_OFFSET_POS + 3'h1) : `IOD_OFFSET_POS; // RULE_09

    // positions 3 and 4 are the farthest extra bytes can reach
    always_comb begin
        x_lo = 8'h00;
        x_hi = 8'h00;
        case (pos)
            3'h2: begin
                x_lo = i_instr.b[2];
                x_hi = i_instr.b[3];
            end
            3'h3: begin
                x_lo = i_instr.b[3];
                x_hi = i_instr.b[4];
            end
            default: begin
                x_lo = 8'h00;
                x_hi = 8'h00;
            end
        endcase
    end

    // length and extra byte layout
    always_comb begin
        layout_d = '0;
        layout_d.offset_present = (b0[`IOD_AMODE_HI:`IOD_AMODE_LO] == 2'h1); // RULE_14
        layout_d.offset = layout_d.offset_present ? i_instr.b[2] : 8'h00; // RULE_14
        layout_d.extra_pos = pos; // RULE_09
        layout_d.extra_count = xcnt; // RULE_04
        if (is_load_pointer_immediate_instruction || is_mm) begin
            layout_d.length = `IOD_LEN_LONG; // RULE_01
            layout_d.extra_count = 2'h0;
            layout_d.extra_pos = `IOD_OFFSET_POS;
        end else begin
            layout_d.length = pos + {1'b0, xcnt}; // RULE_01
        end
        // one byte or a little-endian word; both views offered
        if (is_tsl) begin
            layout_d.imm = {8'h00, x_lo}; // RULE_08
            layout_d.disp = {{8{x_hi[7]}}, x_hi}; // RULE_08 RULE_06
        end else if (xcnt == 2'h1) begin
            layout_d.imm = {8'h00, x_lo}; // RULE_07
            layout_d.disp = {{8{x_lo[7]}}, x_lo}; // RULE_05 RULE_06
        end else if (xcnt == 2'h2) begin
            layout_d.imm = {x_hi, x_lo}; // RULE_07
            layout_d.disp = {x_hi, x_lo}; // RULE_05 RULE_06
        end else begin
            layout_d.imm = 16'h0000;
            layout_d.disp = 16'h0000;
        end
        if (is_load_pointer_immediate_instruction || is_mm) begin
            layout_d.imm = 16'h0000;
            layout_d.disp = 16'h0000;
        end
    end

    // base register choice
    always_comb begin
        case (b1[`IOD_BSEL_HI:`IOD_BSEL_LO])
            2'h0: begin
                base_d = i_pointers.pointer_a; // RULE_17
            end
            2'h1: begin
                base_d = i_pointers.pointer_b; // RULE_17
            end
            2'h2: begin
                base_d = i_pointers.pointer_c; // RULE_17
            end
            default: begin
                base_d = i_pointers.parameter_pointer; // RULE_17
            end
        endcase
    end

    // effective address from the held base, mode and index copy
    always_comb begin
        case (fields_q.address_mode_field)
            AM_BASE: begin
                ea_d = base_q; // RULE_10
            end
            AM_BASE_OFFSET: begin
                ea_d = base_q + {12'h000, layout_q.offset}; // RULE_14
            end
            default: begin
                // index is never sign-extended, so the window spans 64k
                ea_d = base_q + {4'h0, index_q}; // RULE_15 RULE_16
            end
        endcase
    end

    // decode control
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (i_decode_valid) begin
                    state_d = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (i_release) begin
                    state_d = ST_IDLE;
                end
                if (i_decode_valid) begin
                    state_d = ST_ACTIVE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= ST_IDLE;
        end else if (i_ce) begin
            state_q <= state_d;
        end
    end

    // busy kept in its own flop so the port has no decode gate
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            busy_q <= 1'b0;
        end else if (i_ce) begin
            busy_q <= (state_d == ST_ACTIVE);
        end
    end

    // capture of a new instruction
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fields_q <= '0;
            layout_q <= '0;
            base_q   <= `IOD_RESET_ADDR;
        end else if (i_ce && i_decode_valid) begin
            fields_q <= fields_d;
            layout_q <= layout_d;
            base_q   <= base_d; // RULE_13
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            valid_q <= 1'b0;
        end else if (i_ce) begin
            valid_q <= i_decode_valid;
        end
    end

    // index copy; a new decode wins over a pending byte access
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            index_q    <= `IOD_RESET_INDEX;
            index_wr_q <= 1'b0;
        end else if (i_ce) begin
            index_wr_q <= 1'b0;
            if (i_decode_valid) begin
                index_q <= i_index_register;
            end else if (i_byte_done && (state_q == ST_ACTIVE)
                         && (fields_q.address_mode_field == AM_INDEX_AUTO)) begin
                index_q    <= index_q + 16'h0001; // RULE_16
                index_wr_q <= 1'b1; // RULE_16
            end
        end
    end

    // registered address so the port comes from a flop
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ea_q <= `IOD_RESET_ADDR;
        end else if (i_ce) begin
            ea_q <= ea_d; // RULE_15
        end
    end

    assign o_decode_valid = valid_q;
    assign o_fields       = fields_q;
    assign o_layout       = layout_q;
    assign o_eff_addr     = ea_q;
    assign o_index_value  = index_q;
    assign o_index_wr     = index_wr_q;
    assign o_busy         = busy_q;

endmodule : io_chan_decoder

// ==== verification/io_chan_decoder_chk.sv ====
// concurrent checks on the decoder ports
`timescale 1ns/10ps
module io_chan_decoder_chk
    import io_chan_decoder_pkg::*;
(
    input wire logic                              i_mclk,
    input wire logic                              i_sys_rst,
    input wire logic                              i_ce,
    input wire logic                              i_decode_valid,
    input wire io_chan_decoder_pkg::instr_bytes_t i_instr,
    input wire io_chan_decoder_pkg::pointer_set_t i_pointers,
    input wire logic [15:0]                       i_index_register,
    input wire logic                              o_decode_valid,
    input wire io_chan_decoder_pkg::fields_t      o_fields,
    input wire io_chan_decoder_pkg::layout_t      o_layout,
    input wire logic [19:0]                       o_eff_addr,
    input wire logic [15:0]                       o_index_value,
    input wire logic                              o_index_wr,
    input wire logic                              o_busy
);
    instr_bytes_t     iq;
    logic [3:0][19:0] pq;
    logic [15:0]      xq;
    logic [19:0]      base_w;

    // own copy of the taken request, so checks survive released inputs
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            iq <= '0;
            pq <= '0;
            xq <= '0;
        end else if (i_ce && i_decode_valid) begin
            iq <= i_instr;
            pq <= i_pointers;
            xq <= i_index_register;
        end
    end
    assign base_w = pq[~iq.b[1][1:0]];

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    AST_DEC_LAT: assert property (i_ce && i_decode_valid |=> o_decode_valid && o_busy)
        else $error("decode answer late");
    AST_OPSEL: assert property (o_decode_valid |-> o_fields.reg_sel == iq.b[0][7:5]
        && o_fields.bit_num == iq.b[0][7:5]
        && o_fields.ptr_valid == (iq.b[0][7:5] inside {3'h0, 3'h1, 3'h2, 3'h4})) else $error("operand select wrong");
    AST_XCNT: assert property (o_decode_valid |-> o_fields.extra_byte_count_field == iq.b[0][4:3])
        else $error("extra count field wrong");
    AST_MODE: assert property (o_decode_valid |-> o_fields.address_mode_field == iq.b[0][2:1])
        else $error("mode field wrong");
    AST_WIDTH: assert property (o_decode_valid |-> o_fields.word == iq.b[0][0])
        else $error("width bit wrong");
    AST_OPC: assert property (o_decode_valid |-> o_fields.opcode == iq.b[1][7:2]
        && o_fields.base_select_field == iq.b[1][1:0]) else $error("second byte fields wrong");
    AST_LEN: assert property (o_decode_valid |-> o_layout.length >= 3'h2 && o_layout.length <= 3'h6)
        else $error("length out of range");
    AST_EA_OFF: assert property (o_decode_valid && i_ce && !i_decode_valid
        && o_fields.address_mode_field == AM_BASE_OFFSET |=> o_eff_addr == base_w + 20'(iq.b[2]))
        else $error("offset address wrong");
    AST_EA_IDX: assert property (o_decode_valid && i_ce && !i_decode_valid
        && o_fields.address_mode_field == AM_BASE_INDEX |=> o_eff_addr == base_w + {4'h0, xq})
        else $error("index address wrong");
    AST_IDX_INC: assert property (o_index_wr && $past(i_ce) |-> o_index_value == $past(o_index_value) + 16'h0001)
        else $error("index step wrong");

    cover property (o_index_wr);
    cover property (o_decode_valid && o_fields.address_mode_field == AM_BASE_OFFSET);
    cover property (o_decode_valid && o_layout.length == 3'h6);
endmodule : io_chan_decoder_chk

// ==== verification/io_chan_fetch_model.sv ====
// far-side fetch and execute model feeding the decoder
`timescale 1ns/10ps
module io_chan_fetch_model (
    input  wire logic                         i_mclk,
    output logic                              o_decode_valid,
    output io_chan_decoder_pkg::instr_bytes_t o_instr,
    output io_chan_decoder_pkg::pointer_set_t o_pointers,
    output logic [15:0]                       o_index,
    output logic                              o_byte_done,
    output logic                              o_release
);
    initial begin
        o_decode_valid = 1'b0;
        o_instr = '0;
        o_pointers = '0;
        o_index = 16'h0000;
        o_byte_done = 1'b0;
        o_release = 1'b0;
    end

    task automatic issue(input logic [47:0] bytes, input logic [79:0] ptrs, input logic [15:0] idx);
        @(posedge i_mclk) #1;
        o_instr = bytes;
        o_pointers = ptrs;
        o_index = idx;
        o_decode_valid = 1'b1;
        @(posedge i_mclk) #1;
        o_decode_valid = 1'b0;
        // released lines turn over, so a late sample shows up
        o_instr = ~bytes;
        o_pointers = ~ptrs;
        o_index = ~idx;
    endtask : issue

    task automatic pulse(input logic rel);
        @(posedge i_mclk) #1;
        o_byte_done = !rel;
        o_release = rel;
        @(posedge i_mclk) #1;
        o_byte_done = 1'b0;
        o_release = 1'b0;
    endtask : pulse
endmodule : io_chan_fetch_model

// ==== verification/io_chan_decoder_tb_top.sv ====
// self-checking testbench for the instruction decoder
`timescale 1ns/10ps
module io_chan_decoder_tb_top;
    import io_chan_decoder_pkg::*;
    logic mclk, sys_rst, f_valid, byte_done, release_p, dec_valid, index_wr, busy;
    instr_bytes_t instr;
    pointer_set_t ptrs;
    fields_t      fields;
    layout_t      layout;
    logic [15:0]  idx, index_value;
    logic [19:0]  eff_addr;
    int           fails = 0;
    int           num_checks = 0;
    localparam logic [79:0] P = {20'hA_1111, 20'hB_2222, 20'hF_8000, 20'hC_4444};

    io_chan_decoder i_io_chan_decoder (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_ce(1'b1),
        .i_decode_valid(f_valid), .i_instr(instr), .i_pointers(ptrs), .i_index_register(idx),
        .i_byte_done(byte_done), .i_release(release_p), .o_decode_valid(dec_valid), .o_fields(fields),
        .o_layout(layout), .o_eff_addr(eff_addr), .o_index_value(index_value), .o_index_wr(index_wr),
        .o_busy(busy));
    io_chan_fetch_model i_io_chan_fetch_model (.i_mclk(mclk), .o_decode_valid(f_valid), .o_instr(instr),
        .o_pointers(ptrs), .o_index(idx), .o_byte_done(byte_done), .o_release(release_p));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic t_fields();
        logic [7:0] b0;
        logic [7:0] b1;
        for (int i = 0; i < 256; i++) begin
            b0 = 8'(i);
            b1 = ~b0;
            i_io_chan_fetch_model.issue({32'h0000_0000, b1, b0}, P, 16'h0000);
            chk({dec_valid, busy}, 2'b11, "decode answer");
            chk(fields.is_test_and_set_lock, b0[4:3] == 2'h3, "tsl");
            chk(fields.reg_sel, b0[7:5], "reg");
            chk(fields.bit_num, b0[7:5], "bit");
            chk(fields.ptr_valid, b0[7:5] inside {3'h0, 3'h1, 3'h2, 3'h4}, "ptr");
            chk(fields.extra_byte_count_field, b0[4:3], "xcnt");
            chk(fields.address_mode_field, b0[2:1], "mode");
            chk(fields.word, b0[0], "width");
            chk(fields.opcode, b1[7:2], "opc");
            chk(fields.base_select_field, b1[1:0], "base");
            chk(layout.length, 3'h2 + (b0[2:1] == 2'h1) + (b0[4:3] == 2'h3 ? 3'h2 : b0[4:3]), "len");
        end
        $display("test fields done");
    endtask : t_fields

    task automatic t_layout();
        // each entry: bytes, then length, extra position, displacement, immediate
        logic [47:0] bv[5] = '{48'h0000_85F0_EC0A, 48'h0000_1234_EC11, 48'h0000_9055_EC18,
                               48'h4433_2211_0831, 48'h4433_2211_9100};
        logic [47:0] ev[5] = '{48'h0403_FF85_0085, 48'h0402_1234_1234, 48'h0402_FF90_0055,
                               48'h0600_0000_0000, 48'h0600_0000_0000};
        for (int i = 0; i < 5; i++) begin
            i_io_chan_fetch_model.issue(bv[i], P, 16'h0000);
            chk(layout.length, ev[i][42:40], "length");
            chk({fields.is_load_pointer_immediate, fields.is_mem_move},
                (i == 3) ? 2'b10 : ((i == 4) ? 2'b01 : 2'b00), "long form");
            chk(layout.extra_count, (i == 0) ? 2'h1 : ((i < 3) ? 2'h2 : 2'h0), "extra count");
            if (ev[i][39:32] != 8'h00) begin
                chk(layout.extra_pos, ev[i][34:32], "position");
            end
            chk(layout.disp, ev[i][31:16], "disp");
            chk(layout.imm, ev[i][15:0], "imm");
        end
        chk({layout.offset_present, layout.offset}, 9'h000, "no offset");
        $display("test layout done");
    endtask : t_layout

    task automatic t_addr();
        logic [19:0] pa[4] = '{20'hA_1111, 20'hB_2222, 20'hF_8000, 20'hC_4444};
        for (int s = 0; s < 4; s++) begin
            i_io_chan_fetch_model.issue({40'h00_0000_00EC, 8'h00} | (48'(s) << 8), P, 16'h1234);
            @(posedge mclk) #1;
            chk(eff_addr, pa[s], "base only");
        end
        i_io_chan_fetch_model.issue(48'h0000_00F0_EC02, P, 16'h1234);
        @(posedge mclk) #1;
        chk(eff_addr, 20'hA_1201, "offset");
        i_io_chan_fetch_model.issue(48'h0000_0000_EE04, P, 16'hFFFF);
        @(posedge mclk) #1;
        chk(eff_addr, 20'h0_7FFF, "index no sign");
        $display("test address done");
    endtask : t_addr

    task automatic t_auto();
        i_io_chan_fetch_model.pulse(1'b1);
        chk(busy, 1'b0, "released");
        // not busy: a stray access strobe must be ignored
        i_io_chan_fetch_model.pulse(1'b0);
        chk(index_wr, 1'b0, "idle strobe");
        i_io_chan_fetch_model.issue(48'h0000_0000_ED06, P, 16'hFFFE);
        @(posedge mclk) #1;
        chk(eff_addr, 20'hC_2220, "auto start");
        for (int n = 1; n <= 2; n++) begin
            i_io_chan_fetch_model.pulse(1'b0);
            chk({index_wr, index_value}, {1'b1, 16'hFFFE + 16'(n)}, "auto step");
        end
        @(posedge mclk) #1;
        chk(eff_addr, 20'hB_2222, "auto wrap");
        i_io_chan_fetch_model.pulse(1'b1);
        chk(busy, 1'b0, "end");
        $display("test auto increment done");
    endtask : t_auto

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        report_and_stop();
    end

    initial begin
        sys_rst = 1'b1;
        repeat (4) @(posedge mclk);
        #1 sys_rst = 1'b0;
        t_fields();
        t_layout();
        t_addr();
        t_auto();
        report_and_stop();
    end
endmodule : io_chan_decoder_tb_top

bind io_chan_decoder io_chan_decoder_chk i_io_chan_decoder_chk (.i_mclk, .i_sys_rst, .i_ce, .i_decode_valid,
    .i_instr, .i_pointers, .i_index_register, .o_decode_valid, .o_fields, .o_layout, .o_eff_addr,
    .o_index_value, .o_index_wr, .o_busy);
